// >>> csr_pkg.sv
/*
 * csr_pkg: constants, state codes and the output carrier of the
 * charger setpoint register bank.
 * Assumes a 100 MHz system clock; the management bus runs far slower.
 */
package csr_pkg;
	// bus addressing
	localparam logic [6:0] DEV_ADDR = 7'h09;
	localparam logic [7:0] REG_BAT_CUR = 8'h14;
	localparam logic [7:0] REG_BAT_VOLT = 8'h15;
	localparam logic [7:0] REG_ADP_CUR = 8'h3F;
	localparam logic [7:0] REG_MAKER = 8'hFE;
	localparam logic [7:0] REG_PART = 8'hFF;

	// reset values
	localparam logic [15:0] RST_BAT_CUR = 16'h0000;
	localparam logic [15:0] RST_BAT_VOLT = 16'h0000;
	localparam logic [15:0] RST_ADP_CUR = 16'h0080;

	// bit counter of one byte plus acknowledge slot
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// count after start; the clock fall that follows wraps it to bit 0
	localparam logic [3:0] PRE_BIT = 4'hF;

	// setpoint field layout
	localparam int VOLT_LSB = 4;
	localparam int VOLT_MSB = 14;
	localparam int CUR_LSB = 7;
	localparam int CUR_MSB = 12;
	localparam int CUR_TOP = 15;
	localparam logic [14:0] VOLT_MAX_MV = 15'h4B00;
	localparam logic [14:0] VOLT_MIN_MV = 15'h0400;
	localparam logic [10:0] VOLT_CODE_MAX = 11'h4B0;
	localparam logic [15:0] CUR_EN_MIN = 16'h007F;
	localparam logic [15:0] VOLT_EN_MIN = 16'h000F;
	localparam logic [5:0] DAC6_MAX = 6'h3F;
	localparam logic [5:0] FOLD_CODE = 6'h01;

	// timing
	localparam longint CLK_HZ = 100_000_000;
	localparam longint MS_PER_S = 1000;
	localparam int WDOG_TIME_S = 175;
	localparam int SCL_LOW_TIME_MS = 25;
	localparam int MS_TICK_CYCLES = int'(CLK_HZ / MS_PER_S);
	localparam int WDOG_MS = WDOG_TIME_S * int'(MS_PER_S);

	// bus states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_REG = 8'h04,
		ST_WR_LO = 8'h08,
		ST_WR_HI = 8'h10,
		ST_RD_LO = 8'h20,
		ST_RD_HI = 8'h40,
		ST_IGNORE = 8'h80
	} csr_state_t;

	// applied setpoints
	typedef struct packed {
		logic charge_enable;
		logic [10:0] voltage_dac_code;
		logic [5:0] current_dac_code;
		logic [5:0] adapter_dac_code;
	} csr_setpoint_t;
endpackage

// >>> csr_charger_regs.sv
/*
 * csr_charger_regs: management bus target with the setpoint word
 * registers, the applied DAC codes, charge enable and the two timeouts.
 * Assumes open-drain bus wires resolved outside, pulled up when idle,
 * and two battery comparators that may toggle at any time.
 */
`timescale 1ns/10ps

// Behaviour
// - bytes are eight bits, MSB first, ack
// - target only, never starts a transaction
// - acknowledges write 0x12 and read 0x13
// - only word write and word read formats
// - fixed read-only maker and part words
// - current and voltage targets reset to zero
// - enable needs current above 7F, voltage above F
// - 0x14 current target, 0x15 voltage target
// - voltage code is bits 14 to 4
// - voltage requests above 19.2V clamp there
// - below 1.024V gives zero, stops charging
// - voltage bit 15 is ignored
// - current code is bits 12 to 7
// - current requests above 8.064A clamp there
// - below 128mA gives zero current
// - low battery forces 128mA, target kept
// - reads return full word last written
// - words travel low byte then high
// - 175s write or 25ms clock-low timeout
// - one register per write transaction
module csr_charger_regs #(
	parameter int TICK_CYCLES = csr_pkg::MS_TICK_CYCLES,
	parameter logic [15:0] MAKER_CODE = 16'h5A5A, // value is arbitrary
	parameter logic [15:0] PART_CODE = 16'h00A5 // value is arbitrary
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic battery_below_low,
	input wire logic battery_above_high,
	output csr_pkg::csr_setpoint_t setpoint,
	output logic charge_timeout
);
	import csr_pkg::*;

	localparam int WDOG_W = $clog2(WDOG_MS + 1);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	// refuse a tick divider that cannot count
	if (TICK_CYCLES < 2) begin : bad_tick
		$error("TICK_CYCLES must be at least 2");
	end

	// one-hot select {part, maker, adapter, voltage, current}
	function automatic logic [4:0] word_sel(input logic [7:0] ptr);
		case (ptr)
			REG_BAT_CUR: word_sel = 5'h01;
			REG_BAT_VOLT: word_sel = 5'h02;
			REG_ADP_CUR: word_sel = 5'h04;
			REG_MAKER: word_sel = 5'h08;
			REG_PART: word_sel = 5'h10;
			default: word_sel = 5'h00;
		endcase
	endfunction

	logic [3:0] sync1_reg, sync2_reg;
	logic scl_d_reg, sda_d_reg;
	csr_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg, tx_reg, ptr_reg, lo_hold_reg;
	logic [15:0] rd_word_reg, cur_reg, volt_reg, adp_reg;
	logic ack_drive_reg, master_ack_reg, fold_reg, timeout_reg;
	logic [TICK_W-1:0] tick_cnt_reg;
	logic [WDOG_W-1:0] wdog_ms_reg;
	logic [5:0] scl_low_ms_reg;

	// two-stage synchronisers {above_high, below_low, sda, scl}
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= 4'h3;
			sync2_reg <= 4'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			sync1_reg <= {battery_above_high, battery_below_low, sda_in, scl_in};
			sync2_reg <= sync1_reg;
			scl_d_reg <= sync2_reg[0];
			sda_d_reg <= sync2_reg[1];
		end
	end

	// bus event decode
	wire scl_s = sync2_reg[0];
	wire sda_s = sync2_reg[1];
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire in_byte = bit_cnt_reg < ACK_SLOT;
	wire byte_end = scl_fall & (bit_cnt_reg == LAST_BIT);
	wire ack_end = scl_fall & (bit_cnt_reg == ACK_SLOT);
	wire addr_hit = shift_reg[7:1] == DEV_ADDR;
	wire is_read = shift_reg[0];
	wire scl_timeout = scl_low_ms_reg == 6'(SCL_LOW_TIME_MS);
	wire ms_tick = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);

	// register decode and read mux
	wire [4:0] sel = word_sel(ptr_reg);
	wire [15:0] rd_mux = ({16{sel[0]}} & cur_reg) | ({16{sel[1]}} & volt_reg)
		| ({16{sel[2]}} & adp_reg) | ({16{sel[3]}} & MAKER_CODE)
		| ({16{sel[4]}} & PART_CODE);
	wire commit = byte_end & (state_reg == ST_WR_HI);
	wire [15:0] wr_word = {shift_reg, lo_hold_reg};
	wire wr_cur = commit & sel[0];
	wire wr_volt = commit & sel[1];
	wire wr_adp = commit & sel[2];

	// acknowledge choice at end of a received byte
	wire ack_this = ((state_reg == ST_ADDR) & addr_hit) | (state_reg == ST_REG)
		| (state_reg == ST_WR_LO) | (state_reg == ST_WR_HI);

	// state after the acknowledge slot
	csr_state_t state_after;
	always_comb begin
		case (state_reg)
			ST_ADDR: state_after = addr_hit ? (is_read ? ST_RD_LO : ST_REG) : ST_IGNORE;
			ST_REG: state_after = ST_WR_LO;
			ST_WR_LO: state_after = ST_WR_HI;
			ST_WR_HI: state_after = ST_IGNORE;
			ST_RD_LO: state_after = master_ack_reg ? ST_RD_HI : ST_IGNORE;
			default: state_after = ST_IGNORE;
		endcase
	end

	// open-drain data: ack low or transmitted zero bits
	wire tx_state = (state_reg == ST_RD_LO) | (state_reg == ST_RD_HI);
	assign sda_out = 1'b0;
	assign sda_oe = ack_drive_reg | (tx_state & in_byte & ~tx_reg[7]);

	// bit and byte sequencing, only in answer to the host
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'hFF;
			ptr_reg <= 8'h00;
			lo_hold_reg <= 8'h00;
			rd_word_reg <= 16'h0000;
			ack_drive_reg <= 1'b0;
			master_ack_reg <= 1'b0;
		end else if (stop_cond | scl_timeout) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			ack_drive_reg <= 1'b0;
			tx_reg <= 8'hFF;
		end else if (start_cond) begin
			state_reg <= ST_ADDR;
			bit_cnt_reg <= PRE_BIT;
			ack_drive_reg <= 1'b0;
			tx_reg <= 8'hFF;
		end else if (scl_rise & in_byte) begin
			shift_reg <= {shift_reg[6:0], sda_s};
		end else if (scl_rise) begin
			master_ack_reg <= ~sda_s;
		end else if (byte_end) begin
			bit_cnt_reg <= ACK_SLOT;
			ack_drive_reg <= ack_this;
			if (state_reg == ST_REG) begin
				ptr_reg <= shift_reg;
			end
			if (state_reg == ST_WR_LO) begin
				lo_hold_reg <= shift_reg;
			end
		end else if (ack_end) begin
			bit_cnt_reg <= 4'h0;
			ack_drive_reg <= 1'b0;
			state_reg <= state_after;
			if (state_after == ST_RD_LO) begin
				rd_word_reg <= rd_mux;
				tx_reg <= rd_mux[7:0];
			end else if (state_after == ST_RD_HI) begin
				tx_reg <= rd_word_reg[15:8];
			end else begin
				tx_reg <= 8'hFF;
			end
		end else if (scl_fall) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			tx_reg <= {tx_reg[6:0], 1'b1};
		end
	end

	// setpoint words, written only after the high byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur_reg <= RST_BAT_CUR;
			volt_reg <= RST_BAT_VOLT;
			adp_reg <= RST_ADP_CUR;
		end else begin
			if (wr_cur) cur_reg <= wr_word;
			if (wr_volt) volt_reg <= wr_word;
			if (wr_adp) adp_reg <= wr_word;
		end
	end

	// millisecond tick and the two timeout counters
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_cnt_reg <= '0;
			wdog_ms_reg <= '0;
			scl_low_ms_reg <= 6'h00;
		end else begin
			tick_cnt_reg <= ms_tick ? '0 : tick_cnt_reg + TICK_W'(1);
			if (wr_cur | wr_volt) begin
				wdog_ms_reg <= '0;
			end else if (ms_tick & (wdog_ms_reg != WDOG_W'(WDOG_MS))) begin
				wdog_ms_reg <= wdog_ms_reg + WDOG_W'(1);
			end
			if (scl_s) begin
				scl_low_ms_reg <= 6'h00;
			end else if (ms_tick & ~scl_timeout) begin
				scl_low_ms_reg <= scl_low_ms_reg + 6'h01;
			end
		end
	end

	// timeout flag: a clock-low expiry wins over a clearing write; a clearing write wins over watchdog expiry
	wire wdog_expired = wdog_ms_reg == WDOG_W'(WDOG_MS);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			timeout_reg <= 1'b0;
		end else if (scl_timeout | (wdog_expired & ~(wr_cur | wr_volt))) begin
			timeout_reg <= 1'b1;
		end else if (wr_cur | wr_volt) begin
			timeout_reg <= 1'b0;
		end
	end
	assign charge_timeout = timeout_reg;

	// low-battery foldback with hysteresis
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fold_reg <= 1'b0;
		end else if (sync2_reg[2]) begin
			fold_reg <= 1'b1;
		end else if (sync2_reg[3]) begin
			fold_reg <= 1'b0;
		end
	end

	// setpoint extraction, clamping and enable
	wire [14:0] volt_req = volt_reg[VOLT_MSB:0];
	wire volt_low = volt_req < VOLT_MIN_MV;
	wire [10:0] volt_code = (volt_req > VOLT_MAX_MV) ? VOLT_CODE_MAX
		: volt_low ? 11'h000 : volt_reg[VOLT_MSB:VOLT_LSB];
	wire cur_over = |cur_reg[CUR_TOP:CUR_MSB+1];
	wire [5:0] cur_raw = cur_over ? DAC6_MAX : cur_reg[CUR_MSB:CUR_LSB];
	wire [5:0] adp_raw = (|adp_reg[CUR_TOP:CUR_MSB+1]) ? DAC6_MAX : adp_reg[CUR_MSB:CUR_LSB];
	wire en_next = (cur_reg > CUR_EN_MIN) & (volt_reg > VOLT_EN_MIN)
		& ~volt_low & ~timeout_reg;
	csr_setpoint_t sp_next;
	assign sp_next = '{
		charge_enable: en_next,
		voltage_dac_code: volt_code,
		current_dac_code: fold_reg ? FOLD_CODE : cur_raw,
		adapter_dac_code: adp_raw
	};

	// registered outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			setpoint <= '0;
		end else begin
			setpoint <= sp_next;
		end
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_addr_match;
		byte_end && (state_reg == ST_ADDR) && addr_hit;
	endsequence
	sequence s_read_addr;
		ack_end && (state_reg == ST_ADDR) && addr_hit && is_read;
	endsequence
	sequence s_bad_write;
		commit && !(|sel[2:0]);
	endsequence

	addr_ack_a: assert property (s_addr_match |=> ack_drive_reg && sda_oe)
		else $error("own address not acknowledged");
	idle_quiet_a: assert property ((state_reg == ST_IDLE) |-> !sda_oe)
		else $error("data line driven while idle");
	word_commit_a: assert property (wr_cur |=> cur_reg == $past(wr_word))
		else $error("current word not stored after high byte");
	one_word_a: assert property (ack_end && (state_reg == ST_WR_HI)
		|=> (state_reg == ST_IGNORE) || (state_reg == ST_IDLE))
		else $error("write advanced past one word");
	ro_write_a: assert property (s_bad_write
		|=> $stable(cur_reg) && $stable(volt_reg) && $stable(adp_reg))
		else $error("unmapped or read-only write changed state");
	read_load_a: assert property (s_read_addr
		|=> (rd_word_reg == $past(rd_mux)) && (tx_reg == rd_word_reg[7:0]))
		else $error("read did not load low byte of word");
	volt_clamp_a: assert property ((volt_req > VOLT_MAX_MV)
		|=> setpoint.voltage_dac_code == VOLT_CODE_MAX)
		else $error("voltage code not clamped");
	volt_floor_a: assert property (volt_low
		|=> (setpoint.voltage_dac_code == 11'h000) && !setpoint.charge_enable)
		else $error("low voltage request not zeroed");
	enable_min_a: assert property (((cur_reg <= CUR_EN_MIN) || (volt_reg <= VOLT_EN_MIN))
		|=> !setpoint.charge_enable)
		else $error("charging enabled below thresholds");
	cur_clamp_a: assert property (!fold_reg && cur_over
		|=> setpoint.current_dac_code == DAC6_MAX)
		else $error("current code not clamped");
	fold_force_a: assert property (fold_reg |=> setpoint.current_dac_code == FOLD_CODE)
		else $error("foldback current not applied");
	timeout_stop_a: assert property (scl_timeout |=> timeout_reg ##1 !setpoint.charge_enable)
		else $error("clock-low timeout did not stop charging");
endmodule // csr_charger_regs

// >>> csr_host_model.sv
/*
 * csr_host_model: management bus host that clocks the bus and pulls data low.
 * Assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/10ps
module csr_host_model (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low,
	output logic [3:0] ack_bits,
	output logic [15:0] rd_word,
	output logic rd_done
);
	import csr_pkg::*;
	// both wires released at time zero
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		ack_bits = 4'h0;
		rd_word = 16'h0000;
		rd_done = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one clock pulse, data sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		wt(6);
		scl <= 1'b1;
		wt(6);
		r = sda_line;
		wt(6);
		scl <= 1'b0;
		wt(6);
	endtask
	// start, also usable as repeated start
	task automatic start_c();
		sda_low <= 1'b0;
		wt(6);
		scl <= 1'b1;
		wt(6);
		sda_low <= 1'b1;
		wt(6);
		scl <= 1'b0;
		wt(6);
	endtask
	task automatic stop_c();
		sda_low <= 1'b1;
		wt(6);
		scl <= 1'b1;
		wt(6);
		sda_low <= 1'b0;
		wt(12);
	endtask
	// eight bits msb first, then the ack slot
	task automatic send_byte(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack_bits <= {ack_bits[2:0], ~r};
	endtask
	task automatic recv_byte(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(~ack, r);
	endtask
	// word write, n data bytes sent low byte first
	task automatic write_word(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [15:0] d, input int n);
		ack_bits <= 4'h0;
		start_c();
		send_byte({dev, 1'b0});
		send_byte(ptr);
		if (n > 0) send_byte(d[7:0]);
		if (n > 1) send_byte(d[15:8]);
		if (n > 2) send_byte(8'hA5);
		stop_c();
	endtask
	// pointer write and stop, then read low byte acked, high byte not
	task automatic read_word(input logic [7:0] ptr);
		logic [7:0] lo;
		logic [7:0] hi;
		start_c();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(ptr);
		stop_c();
		start_c();
		send_byte({DEV_ADDR, 1'b1});
		recv_byte(1'b1, lo);
		recv_byte(1'b0, hi);
		stop_c();
		rd_word <= {hi, lo};
		rd_done <= 1'b1;
		wt(1);
		rd_done <= 1'b0;
	endtask
	// clock held low for n cycles
	task automatic hold_scl(input int n);
		scl <= 1'b0;
		wt(n);
		scl <= 1'b1;
		wt(6);
	endtask
endmodule // csr_host_model

// >>> testbench.sv
/*
 * testbench: drives the setpoint bank through the host model and checks
 * read words, acks and applied setpoints.
 * Assumes a short ms tick so the bus clock timeout fits the run.
 */
`timescale 1ns/10ps
module testbench;
	import csr_pkg::*;
	localparam int TICKS = 2;
	localparam logic [15:0] MAKER = 16'h3C3C; // value is arbitrary
	localparam logic [15:0] PART = 16'h0C0C; // value is arbitrary
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic bat_low = 1'b0;
	logic bat_high = 1'b0;
	logic scl, host_sda_low, sda_out, sda_oe, charge_timeout, rd_done;
	logic [3:0] ack_bits;
	logic [15:0] rd_word, cur, volt, adp, c, v;
	logic fold, tmo;
	csr_setpoint_t setpoint;
	int n_fail = 0;
	int tests_run = 0;
	logic [15:0] exp_q[$];
	logic [15:0] ctab[6] = '{16'h0000, 16'h007F, 16'h0080, 16'h1F80, 16'h2000, 16'hFFFF};
	logic [15:0] vtab[6] = '{16'h0400, 16'h03FF, 16'h000F, 16'h4B00, 16'h4B10, 16'hC400};
	// open-drain data wire with pull-up
	wire logic sda_line = ~(host_sda_low | (sda_oe & ~sda_out));
	always #5 clk = ~clk;
	csr_charger_regs #(.TICK_CYCLES(TICKS), .MAKER_CODE(MAKER), .PART_CODE(PART))
		csr_charger_regs_inst (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .battery_below_low(bat_low),
		.battery_above_high(bat_high), .setpoint(setpoint), .charge_timeout(charge_timeout));
	csr_host_model csr_host_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl),
		.sda_low(host_sda_low), .ack_bits(ack_bits), .rd_word(rd_word), .rd_done(rd_done));
	task automatic complete_run();
		$display("compared %0d, failed %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic err(input string m);
		n_fail++;
		$display("ERROR at %0t: %s", $time, m);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// expected applied codes from the stored targets
	function automatic csr_setpoint_t model();
		csr_setpoint_t s;
		s.voltage_dac_code = (volt[14:0] > VOLT_MAX_MV) ? VOLT_CODE_MAX :
			(volt[14:0] < VOLT_MIN_MV) ? 11'h000 : volt[VOLT_MSB:VOLT_LSB];
		s.current_dac_code = fold ? FOLD_CODE :
			(|cur[15:13]) ? DAC6_MAX : cur[CUR_MSB:CUR_LSB];
		s.adapter_dac_code = (|adp[15:13]) ? DAC6_MAX : adp[12:7];
		s.charge_enable = cur > CUR_EN_MIN && volt > VOLT_EN_MIN &&
			volt[14:0] >= VOLT_MIN_MV && !tmo;
		return s;
	endfunction
	task automatic compare_word(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) err($sformatf("read %h, wanted %h", g, e));
	endtask
	task automatic compare_set();
		tests_run++;
		if ({setpoint, charge_timeout} !== {model(), tmo}) err("setpoint mismatch");
	endtask
	task automatic compare_ack(input logic [3:0] e);
		tests_run++;
		if (ack_bits !== e) err($sformatf("acks %b, wanted %b", ack_bits, e));
	endtask
	task automatic rd(input logic [7:0] p, input logic [15:0] e);
		exp_q.push_back(e);
		csr_host_model_inst.read_word(p);
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n,
		input logic [3:0] ea);
		csr_host_model_inst.write_word(DEV_ADDR, p, d, n);
		compare_ack(ea);
	endtask
	// watcher: oldest expected word against each finished read
	always @(posedge clk) begin
		if (rd_done === 1'b1) begin
			if (exp_q.size() == 0) err("read with no expectation");
			else compare_word(rd_word, exp_q.pop_front());
		end
	end
	initial begin
		wt(90000);
		err("run limit reached");
		complete_run();
	end
	initial begin
		void'($urandom(32'hc514));
		cur = RST_BAT_CUR;
		volt = RST_BAT_VOLT;
		adp = RST_ADP_CUR;
		fold = 1'b0;
		tmo = 1'b0;
		wt(16);
		reset <= 1'b0;
		wt(4);
		compare_set();
		rd(REG_BAT_CUR, RST_BAT_CUR);
		rd(REG_BAT_VOLT, RST_BAT_VOLT);
		rd(REG_ADP_CUR, RST_ADP_CUR);
		wr(REG_MAKER, 16'h1234, 2, 4'hF);
		rd(REG_MAKER, MAKER);
		rd(REG_PART, PART);
		wr(8'h20, 16'hBEEF, 2, 4'hF);
		rd(8'h20, 16'h0000);
		wr(REG_ADP_CUR, 16'h0A80, 2, 4'hF);
		adp = 16'h0A80;
		rd(REG_ADP_CUR, adp);
		// boundary words first, then random words
		for (int i = 0; i < 10; i++) begin
			c = (i < 6) ? ctab[i] : 16'($urandom());
			v = (i < 6) ? vtab[i] : 16'($urandom());
			wr(REG_BAT_CUR, c, 2, 4'hF);
			cur = c;
			wr(REG_BAT_VOLT, v, 2, 4'hF);
			volt = v;
			wt(10);
			compare_set();
			rd(REG_BAT_CUR, c);
			rd(REG_BAT_VOLT, v);
		end
		wr(REG_BAT_CUR, 16'h1000, 2, 4'hF);
		cur = 16'h1000;
		wr(REG_BAT_CUR, 16'h0F80, 1, 4'h7);
		rd(REG_BAT_CUR, cur);
		wr(REG_BAT_CUR, 16'h0180, 3, 4'hE);
		cur = 16'h0180;
		rd(REG_BAT_VOLT, volt);
		csr_host_model_inst.write_word(7'h0A, REG_BAT_CUR, 16'h0000, 2);
		compare_ack(4'h0);
		rd(REG_BAT_CUR, cur);
		// low battery foldback and recovery
		bat_low <= 1'b1;
		fold = 1'b1;
		wt(10);
		compare_set();
		bat_low <= 1'b0;
		wt(10);
		compare_set();
		bat_high <= 1'b1;
		fold = 1'b0;
		wt(10);
		compare_set();
		bat_high <= 1'b0;
		// bus clock low just short of, then past, the limit
		csr_host_model_inst.hold_scl(20 * TICKS);
		compare_set();
		csr_host_model_inst.hold_scl(25 * TICKS + 20);
		tmo = 1'b1;
		compare_set();
		wr(REG_BAT_VOLT, volt, 2, 4'hF);
		tmo = 1'b0;
		wt(10);
		compare_set();
		for (int k = 0; k < 100 && exp_q.size() > 0; k++) wt(1);
		if (exp_q.size() > 0) err("reads never finished");
		complete_run();
	end
endmodule // testbench
